// ==== mies_cfg.svh ====
// constants for the instruction execution subset block
`ifndef MIES_CFG_SVH
`define MIES_CFG_SVH

`define MIES_DATA_W 8
`define MIES_PC_W 11
`define MIES_STACK_DEPTH 6
`define MIES_SP_W 3
`define MIES_WDT_W 8
`define MIES_PRE_W 7
`define MIES_ZERO8 8'h00
`define MIES_ONE8 8'h01
`define MIES_NIB_MAX 4'h9
`define MIES_NIB_ADJ 4'h6
`define MIES_PC_ONE 11'h001
`define MIES_PC_RST 11'h000
`define MIES_CLKS_PER_CYC 3'h4
`define MIES_CYC_LAST 3'h3
`define MIES_CYC_ZERO 3'h0
`define MIES_ACC_RST 8'h00
`define MIES_TOP_BIT 7

`endif

// ==== mies_pkg.sv ====
// types for the instruction execution subset block
`default_nettype none
package mies_pkg;
  typedef enum logic [4:0] {
    MIES_OP_IDLE,
    MIES_OP_WDT_CLR,
    MIES_OP_WDT_PRE1,
    MIES_OP_WDT_PRE2,
    MIES_OP_INV_MEM,
    MIES_OP_INV_ACC,
    MIES_OP_DEC_ADJ,
    MIES_OP_DEC_MEM,
    MIES_OP_DEC_ACC,
    MIES_OP_INC_MEM,
    MIES_OP_INC_ACC,
    MIES_OP_HALT,
    MIES_OP_JUMP,
    MIES_OP_MOV_M2A,
    MIES_OP_MOV_I2A,
    MIES_OP_MOV_A2M,
    MIES_OP_OR_MEM_ACC,
    MIES_OP_OR_IMM_ACC,
    MIES_OP_OR_TO_MEM,
    MIES_OP_RET,
    MIES_OP_RET_IMM,
    MIES_OP_RET_IRQ,
    MIES_OP_ROL_MEM,
    MIES_OP_ROL_ACC
  } mies_op_t;

  typedef enum logic [1:0] {
    MIES_ST_READY,
    MIES_ST_EXEC,
    MIES_ST_EXTRA,
    MIES_ST_HALTED
  } mies_state_t;
endpackage
`default_nettype wire

// ==== mies_alu_if.sv ====
// interface carrying operands and results between exec core and alu
`timescale 1ns/10ps
`default_nettype none
`include "mies_cfg.svh"
interface mies_alu_if;
  mies_pkg::mies_op_t op;
  logic [`MIES_DATA_W-1:0] acc;
  logic [`MIES_DATA_W-1:0] mem;
  logic [`MIES_DATA_W-1:0] imm;
  logic half_carry;
  logic carry;
  logic [`MIES_DATA_W-1:0] result;
  logic to_mem;
  logic to_acc;
  logic zero_upd;
  logic carry_upd;
  logic carry_out;
  modport core (output op, acc, mem, imm, half_carry, carry,
                input result, to_mem, to_acc, zero_upd, carry_upd, carry_out);
  modport alu (input op, acc, mem, imm, half_carry, carry,
               output result, to_mem, to_acc, zero_upd, carry_upd, carry_out);
endinterface
`default_nettype wire

// ==== mies_alu.sv ====
// combinational data path for the arithmetic and logic operations
`timescale 1ns/10ps
`default_nettype none
`include "mies_cfg.svh"
module mies_alu (
  mies_alu_if.alu bus
);
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic nib_carry;

  // ----------------------------------------------------------------
  // result select and destination
  // ----------------------------------------------------------------
  always_comb begin
    bus.result = bus.mem;
    bus.to_mem = 1'b0;
    bus.to_acc = 1'b0;
    bus.zero_upd = 1'b0;
    bus.carry_upd = 1'b0;
    bus.carry_out = bus.carry;
    lo_sum = {1'b0, bus.acc[3:0]};
    hi_sum = {1'b0, bus.acc[7:4]};
    nib_carry = 1'b0;
    case (bus.op)
      mies_pkg::MIES_OP_INV_MEM: begin
        bus.result = ~bus.mem; // [RULE_04]
        bus.to_mem = 1'b1;
        bus.zero_upd = 1'b1;
      end
      mies_pkg::MIES_OP_INV_ACC: begin
        bus.result = ~bus.mem; // [RULE_05]
        bus.to_acc = 1'b1;
        bus.zero_upd = 1'b1;
      end
      mies_pkg::MIES_OP_DEC_ADJ: begin
        // low nibble: the intermediate carry is the inverse of half carry
        if (bus.acc[3:0] > `MIES_NIB_MAX || bus.half_carry) begin
          lo_sum = {1'b0, bus.acc[3:0]} + {1'b0, `MIES_NIB_ADJ}; // [RULE_06]
          nib_carry = ~bus.half_carry;
        end
        // high nibble sees the intermediate carry in its compare
        if (({1'b0, bus.acc[7:4]} + {4'h0, nib_carry}) > {1'b0, `MIES_NIB_MAX}
            || bus.carry) begin
          hi_sum = {1'b0, bus.acc[7:4]} + {1'b0, `MIES_NIB_ADJ}
                   + {4'h0, nib_carry}; // [RULE_07]
          bus.carry_out = 1'b1;
        end else begin
          hi_sum = {1'b0, bus.acc[7:4]} + {4'h0, nib_carry};
        end
        bus.result = {hi_sum[3:0], lo_sum[3:0]};
        bus.to_mem = 1'b1; // [RULE_08]
        bus.carry_upd = 1'b1;
      end
      mies_pkg::MIES_OP_DEC_MEM: begin
        bus.result = bus.mem - `MIES_ONE8; // [RULE_09]
        bus.to_mem = 1'b1;
        bus.zero_upd = 1'b1;
      end
      mies_pkg::MIES_OP_DEC_ACC: begin
        bus.result = bus.mem - `MIES_ONE8; // [RULE_09]
        bus.to_acc = 1'b1;
        bus.zero_upd = 1'b1;
      end
      mies_pkg::MIES_OP_INC_MEM: begin
        bus.result = bus.mem + `MIES_ONE8; // [RULE_10]
        bus.to_mem = 1'b1;
        bus.zero_upd = 1'b1;
      end
      mies_pkg::MIES_OP_INC_ACC: begin
        bus.result = bus.mem + `MIES_ONE8; // [RULE_10]
        bus.to_acc = 1'b1;
        bus.zero_upd = 1'b1;
      end
      mies_pkg::MIES_OP_MOV_M2A: begin
        bus.result = bus.mem; // [RULE_14]
        bus.to_acc = 1'b1;
      end
      mies_pkg::MIES_OP_MOV_I2A, mies_pkg::MIES_OP_RET_IMM: begin
        bus.result = bus.imm; // [RULE_14] [RULE_18]
        bus.to_acc = 1'b1;
      end
      mies_pkg::MIES_OP_MOV_A2M: begin
        bus.result = bus.acc; // [RULE_14]
        bus.to_mem = 1'b1;
      end
      mies_pkg::MIES_OP_OR_MEM_ACC: begin
        bus.result = bus.acc | bus.mem; // [RULE_16]
        bus.to_acc = 1'b1;
        bus.zero_upd = 1'b1;
      end
      mies_pkg::MIES_OP_OR_IMM_ACC: begin
        bus.result = bus.acc | bus.imm; // [RULE_16]
        bus.to_acc = 1'b1;
        bus.zero_upd = 1'b1;
      end
      mies_pkg::MIES_OP_OR_TO_MEM: begin
        bus.result = bus.acc | bus.mem; // [RULE_16]
        bus.to_mem = 1'b1;
        bus.zero_upd = 1'b1;
      end
      mies_pkg::MIES_OP_ROL_MEM: begin
        bus.result = {bus.mem[`MIES_TOP_BIT-1:0], bus.mem[`MIES_TOP_BIT]}; // [RULE_20]
        bus.to_mem = 1'b1;
      end
      mies_pkg::MIES_OP_ROL_ACC: begin
        bus.result = {bus.mem[`MIES_TOP_BIT-1:0], bus.mem[`MIES_TOP_BIT]}; // [RULE_21]
        bus.to_acc = 1'b1;
      end
      default: begin
        bus.result = bus.mem;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== mies_exec.sv ====
// execution core for the instruction subset: acc, flags, pc, stack, watchdog
// How it works
// (RULE_01) watchdog clear zeroes counter, power-down, timeout
// (RULE_02) both pre-clears together clear watchdog and flags
// (RULE_03) lone pre-clear only records itself
// (RULE_04) invert byte in place, zero flag only
// (RULE_05) inverted byte to accumulator, zero only
// (RULE_06) low nibble adjust, intermediate carry from half-carry
// (RULE_07) high nibble adjust with intermediate carry, carry
// (RULE_08) decimal adjust writes memory, only carry changes
// (RULE_09) decrement to memory or accumulator, zero flag
// (RULE_10) increment to memory or accumulator, zero flag
// (RULE_11) power-down halts, clears watchdog, pc plus one
// (RULE_12) power-down sets power-down flag, clears timeout
// (RULE_13) jump loads pc from instruction, no flags
// (RULE_14) moves copy bytes without touching flags
// (RULE_15) idle only advances pc by one
// (RULE_16) or into accumulator or memory, zero only
// (RULE_17) return pops pc, two cycles, no flags
// (RULE_18) return with value loads accumulator immediate
// (RULE_19) interrupt return pops pc, sets global enable
// (RULE_20) rotate byte left in place, flags unchanged
// (RULE_21) rotate left into accumulator, byte unchanged
// (RULE_22) pc-writing instructions take one extra cycle
// (RULE_23) zero flag set when result is zero
`timescale 1ns/10ps
`default_nettype none
`include "mies_cfg.svh"
module mies_exec #(
  parameter int DATA_W = `MIES_DATA_W,
  parameter int PC_W = `MIES_PC_W,
  parameter int STACK_DEPTH = `MIES_STACK_DEPTH,
  parameter int SP_W = `MIES_SP_W,
  parameter int WDT_W = `MIES_WDT_W,
  parameter int PRE_W = `MIES_PRE_W
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_op_valid,
  input wire mies_pkg::mies_op_t i_op,
  input wire logic [DATA_W-1:0] i_imm,
  input wire logic [PC_W-1:0] i_jump_addr,
  input wire logic [DATA_W-1:0] i_mem_rdata,
  input wire logic i_wake,
  input wire logic i_wdt_tick,
  input wire logic i_call_push,
  input wire logic i_irq_taken,
  output logic o_op_ready,
  output logic o_mem_we,
  output logic [DATA_W-1:0] o_mem_wdata,
  output logic [DATA_W-1:0] o_acc,
  output logic [PC_W-1:0] o_pc,
  output logic o_zero_flag,
  output logic o_carry_flag,
  output logic o_half_carry_flag,
  output logic o_power_down_flag,
  output logic o_timeout_flag,
  output logic o_global_irq_enable,
  output logic o_halted,
  output logic [WDT_W-1:0] o_wdt_count,
  output logic [PRE_W-1:0] o_wdt_prescale
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mies_pkg::mies_state_t st;
    logic [2:0] clk_cnt;
    logic extra;
    logic [DATA_W-1:0] acc;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic zero;
    logic carry;
    logic half_carry;
    logic power_down;
    logic timeout;
    logic gie;
    logic pre1_seen;
    logic pre2_seen;
    logic [WDT_W-1:0] wdt;
    logic [PRE_W-1:0] pre;
    logic mem_we;
    logic [DATA_W-1:0] mem_wdata;
  } mies_core_t;

  mies_core_t cur_ff;
  mies_core_t nxt_cur;

  mies_alu_if alu_bus ();

  mies_alu u_alu (
    .bus(alu_bus)
  );

  // operands to the alu come from the held state and the request
  assign alu_bus.op = i_op;
  assign alu_bus.acc = cur_ff.acc;
  assign alu_bus.mem = i_mem_rdata;
  assign alu_bus.imm = i_imm;
  assign alu_bus.half_carry = cur_ff.half_carry;
  assign alu_bus.carry = cur_ff.carry;

  logic [SP_W-1:0] sp_dec;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] top_of_stack;
  logic take_op;
  logic pre_both;
  logic wdt_zero_now;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  assign sp_dec = cur_ff.sp - SP_W'(1);
  assign pc_inc = cur_ff.pc + `MIES_PC_ONE;
  assign top_of_stack = cur_ff.stack[sp_dec];
  assign take_op = i_op_valid && (cur_ff.st == mies_pkg::MIES_ST_READY);
  // the pair completes when the other half is already on record
  assign pre_both = (i_op == mies_pkg::MIES_OP_WDT_PRE1 && cur_ff.pre2_seen) ||
                    (i_op == mies_pkg::MIES_OP_WDT_PRE2 && cur_ff.pre1_seen);
  assign wdt_zero_now = take_op && (i_op == mies_pkg::MIES_OP_WDT_CLR ||
                        i_op == mies_pkg::MIES_OP_HALT ||
                        ((i_op == mies_pkg::MIES_OP_WDT_PRE1 ||
                          i_op == mies_pkg::MIES_OP_WDT_PRE2) && pre_both));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.mem_we = 1'b0;
    // watchdog runs from the prescaler unless halted; timeout is sticky
    if (cur_ff.st != mies_pkg::MIES_ST_HALTED && i_wdt_tick) begin
      nxt_cur.pre = cur_ff.pre + PRE_W'(1);
      if (&cur_ff.pre) begin
        nxt_cur.wdt = cur_ff.wdt + WDT_W'(1);
        if (&cur_ff.wdt) begin
          nxt_cur.timeout = 1'b1;
        end
      end
    end
    // interrupt entry pushes pc and drops global enable, when idle
    if (i_irq_taken && cur_ff.st == mies_pkg::MIES_ST_READY && !i_op_valid) begin
      nxt_cur.stack[cur_ff.sp] = cur_ff.pc;
      nxt_cur.sp = cur_ff.sp + SP_W'(1);
      nxt_cur.gie = 1'b0;
    end else if (i_call_push && cur_ff.st == mies_pkg::MIES_ST_READY && !i_op_valid) begin
      nxt_cur.stack[cur_ff.sp] = cur_ff.pc;
      nxt_cur.sp = cur_ff.sp + SP_W'(1);
    end
    case (cur_ff.st)
      mies_pkg::MIES_ST_READY: begin
        if (take_op) begin
          nxt_cur.st = mies_pkg::MIES_ST_EXEC;
          nxt_cur.clk_cnt = `MIES_CYC_ZERO;
          nxt_cur.extra = 1'b0;
          nxt_cur.pc = pc_inc; // [RULE_15]
          // data results from the alu
          if (alu_bus.to_acc) begin
            nxt_cur.acc = alu_bus.result;
          end
          if (alu_bus.to_mem) begin
            nxt_cur.mem_we = 1'b1;
            nxt_cur.mem_wdata = alu_bus.result;
          end
          if (alu_bus.zero_upd) begin
            nxt_cur.zero = (alu_bus.result == `MIES_ZERO8); // [RULE_23]
          end
          if (alu_bus.carry_upd) begin
            nxt_cur.carry = alu_bus.carry_out; // [RULE_08]
          end
          case (i_op)
            mies_pkg::MIES_OP_WDT_CLR: begin
              nxt_cur.power_down = 1'b0; // [RULE_01]
              nxt_cur.timeout = 1'b0;
              nxt_cur.pre1_seen = 1'b0;
              nxt_cur.pre2_seen = 1'b0;
            end
            mies_pkg::MIES_OP_WDT_PRE1, mies_pkg::MIES_OP_WDT_PRE2: begin
              if (pre_both) begin
                nxt_cur.power_down = 1'b0; // [RULE_02]
                nxt_cur.timeout = 1'b0;
                nxt_cur.pre1_seen = 1'b0;
                nxt_cur.pre2_seen = 1'b0;
              end else if (i_op == mies_pkg::MIES_OP_WDT_PRE1) begin
                nxt_cur.pre1_seen = 1'b1; // [RULE_03]
              end else begin
                nxt_cur.pre2_seen = 1'b1; // [RULE_03]
              end
            end
            mies_pkg::MIES_OP_HALT: begin
              nxt_cur.st = mies_pkg::MIES_ST_HALTED; // [RULE_11]
              nxt_cur.power_down = 1'b1; // [RULE_12]
              nxt_cur.timeout = 1'b0;
            end
            mies_pkg::MIES_OP_JUMP: begin
              nxt_cur.pc = i_jump_addr; // [RULE_13]
              nxt_cur.extra = 1'b1; // [RULE_22]
            end
            mies_pkg::MIES_OP_RET, mies_pkg::MIES_OP_RET_IMM,
            mies_pkg::MIES_OP_RET_IRQ: begin
              nxt_cur.pc = top_of_stack; // [RULE_17] [RULE_18]
              nxt_cur.sp = sp_dec;
              nxt_cur.extra = 1'b1; // [RULE_17]
              if (i_op == mies_pkg::MIES_OP_RET_IRQ) begin
                nxt_cur.gie = 1'b1; // [RULE_19]
              end
            end
            default: begin
              nxt_cur.extra = 1'b0;
            end
          endcase
        end
      end
      mies_pkg::MIES_ST_EXEC, mies_pkg::MIES_ST_EXTRA: begin
        // each instruction cycle spans four system clocks
        nxt_cur.clk_cnt = cur_ff.clk_cnt + 3'h1;
        if (cur_ff.clk_cnt == `MIES_CYC_LAST) begin
          nxt_cur.clk_cnt = `MIES_CYC_ZERO;
          if (cur_ff.st == mies_pkg::MIES_ST_EXEC && cur_ff.extra) begin
            nxt_cur.st = mies_pkg::MIES_ST_EXTRA; // [RULE_22]
          end else begin
            nxt_cur.st = mies_pkg::MIES_ST_READY;
          end
        end
      end
      mies_pkg::MIES_ST_HALTED: begin
        // execution stalled until wake; ram and registers hold
        if (i_wake) begin
          nxt_cur.st = mies_pkg::MIES_ST_READY;
        end
      end
      default: begin
        nxt_cur.st = mies_pkg::MIES_ST_READY;
      end
    endcase
    // clearing wins over the tick in the same clock
    if (wdt_zero_now) begin
      nxt_cur.wdt = WDT_W'(0); // [RULE_01] [RULE_02]
      if (i_op == mies_pkg::MIES_OP_HALT) begin
        nxt_cur.pre = PRE_W'(0); // [RULE_11]
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cur_ff <= '0;
      cur_ff.st <= mies_pkg::MIES_ST_READY;
      cur_ff.acc <= `MIES_ACC_RST;
      cur_ff.pc <= `MIES_PC_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_op_ready = (cur_ff.st == mies_pkg::MIES_ST_READY);
  assign o_mem_we = cur_ff.mem_we;
  assign o_mem_wdata = cur_ff.mem_wdata;
  assign o_acc = cur_ff.acc;
  assign o_pc = cur_ff.pc;
  assign o_zero_flag = cur_ff.zero;
  assign o_carry_flag = cur_ff.carry;
  assign o_half_carry_flag = cur_ff.half_carry;
  assign o_power_down_flag = cur_ff.power_down;
  assign o_timeout_flag = cur_ff.timeout;
  assign o_global_irq_enable = cur_ff.gie;
  assign o_halted = (cur_ff.st == mies_pkg::MIES_ST_HALTED);
  assign o_wdt_count = cur_ff.wdt;
  assign o_wdt_prescale = cur_ff.pre;
endmodule
`default_nettype wire

// ==== mies_exec_props.sv ====
// concurrent checks on the execution core ports
`timescale 1ns/10ps
`default_nettype none
`include "mies_cfg.svh"
module mies_exec_props (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_op_valid,
  input wire mies_pkg::mies_op_t i_op,
  input wire logic [`MIES_PC_W-1:0] i_jump_addr,
  input wire logic [`MIES_DATA_W-1:0] i_mem_rdata,
  input wire logic o_op_ready,
  input wire logic o_mem_we,
  input wire logic [`MIES_DATA_W-1:0] o_mem_wdata,
  input wire logic [`MIES_DATA_W-1:0] o_acc,
  input wire logic [`MIES_PC_W-1:0] o_pc,
  input wire logic o_zero_flag,
  input wire logic o_power_down_flag,
  input wire logic o_timeout_flag,
  input wire logic o_global_irq_enable,
  input wire logic [`MIES_WDT_W-1:0] o_wdt_count
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // an op is taken where valid meets ready; pc-writing ops run twice as long
  wire logic take = i_op_valid && o_op_ready;
  wire logic long_op = i_op inside {mies_pkg::MIES_OP_JUMP, mies_pkg::MIES_OP_RET,
    mies_pkg::MIES_OP_RET_IMM, mies_pkg::MIES_OP_RET_IRQ};
  logic [7:0] rd_ff;
  // operand copy so results can be compared one cycle after the take
  always_ff @(posedge i_clk) begin
    rd_ff <= i_mem_rdata;
  end
  wdt_clear_a: assert property (take && i_op == mies_pkg::MIES_OP_WDT_CLR |=>
    o_wdt_count == 8'h00 && !o_power_down_flag && !o_timeout_flag)
    else $error("watchdog clear left counter or flags set");
  halt_flags_a: assert property (take && i_op == mies_pkg::MIES_OP_HALT |=>
    o_power_down_flag && !o_timeout_flag && o_wdt_count == 8'h00 && o_pc == $past(o_pc) + 11'h001)
    else $error("power-down entry wrong");
  jump_pc_a: assert property (take && i_op == mies_pkg::MIES_OP_JUMP |=>
    o_pc == $past(i_jump_addr) && $stable(o_zero_flag))
    else $error("jump target not loaded");
  short_gap_a: assert property (take && !long_op && i_op != mies_pkg::MIES_OP_HALT |=>
    !o_op_ready [*4] ##1 o_op_ready)
    else $error("single cycle op length wrong");
  long_gap_a: assert property (take && long_op |=>
    !o_op_ready [*8] ##1 o_op_ready)
    else $error("pc-writing op length wrong");
  inc_mem_a: assert property (take && i_op == mies_pkg::MIES_OP_INC_MEM |=>
    o_mem_we && o_mem_wdata == rd_ff + 8'h01 && o_zero_flag == (o_mem_wdata == 8'h00) ##1 !o_mem_we)
    else $error("increment to memory wrong");
  inv_acc_a: assert property (take && i_op == mies_pkg::MIES_OP_INV_ACC |=>
    o_acc == ~rd_ff && !o_mem_we)
    else $error("inverse to accumulator wrong");
  rol_acc_a: assert property (take && i_op == mies_pkg::MIES_OP_ROL_ACC |=>
    o_acc == {rd_ff[6:0], rd_ff[7]} && !o_mem_we && $stable(o_zero_flag))
    else $error("rotate to accumulator wrong");
  idle_pc_a: assert property (take && i_op == mies_pkg::MIES_OP_IDLE |=>
    o_pc == $past(o_pc) + 11'h001 && $stable(o_acc) && !o_mem_we)
    else $error("idle op did more than step pc");
  interrupt_return_op_irq_a: assert property (take && i_op == mies_pkg::MIES_OP_RET_IRQ |=>
    o_global_irq_enable)
    else $error("interrupt return left enable low");
  move_flag_a: assert property (take && i_op inside {mies_pkg::MIES_OP_MOV_M2A,
    mies_pkg::MIES_OP_MOV_I2A, mies_pkg::MIES_OP_MOV_A2M} |=> $stable(o_zero_flag))
    else $error("move changed zero flag");
endmodule
bind mies_exec mies_exec_props u_props (.i_clk(i_clk), .i_reset(i_reset),
  .i_op_valid(i_op_valid), .i_op(i_op), .i_jump_addr(i_jump_addr), .i_mem_rdata(i_mem_rdata),
  .o_op_ready(o_op_ready), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc),
  .o_pc(o_pc), .o_zero_flag(o_zero_flag), .o_power_down_flag(o_power_down_flag),
  .o_timeout_flag(o_timeout_flag), .o_global_irq_enable(o_global_irq_enable),
  .o_wdt_count(o_wdt_count));
`default_nettype wire

// ==== mies_exec_tb.sv ====
// self-checking bench for the execution core
`timescale 1ns/10ps
`default_nettype none
`include "mies_cfg.svh"
module mies_exec_tb;
  logic i_clk, i_reset, i_op_valid, i_wake, i_wdt_tick, i_call_push, i_irq_taken;
  mies_pkg::mies_op_t i_op;
  logic [7:0] i_imm, i_mem_rdata, o_mem_wdata, o_acc, o_wdt_count, acc_e;
  logic [10:0] i_jump_addr, o_pc, pc_e;
  logic [6:0] o_wdt_prescale;
  logic o_op_ready, o_mem_we, o_zero_flag, o_carry_flag, o_half_carry_flag, z_e, c_e;
  logic o_power_down_flag, o_timeout_flag, o_global_irq_enable, o_halted;
  int err_count, checked;
  mies_exec DUT (.i_clk(i_clk), .i_reset(i_reset), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_imm(i_imm), .i_jump_addr(i_jump_addr), .i_mem_rdata(i_mem_rdata), .i_wake(i_wake),
    .i_wdt_tick(i_wdt_tick), .i_call_push(i_call_push), .i_irq_taken(i_irq_taken),
    .o_op_ready(o_op_ready), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc),
    .o_pc(o_pc), .o_zero_flag(o_zero_flag), .o_carry_flag(o_carry_flag),
    .o_half_carry_flag(o_half_carry_flag), .o_power_down_flag(o_power_down_flag),
    .o_timeout_flag(o_timeout_flag), .o_global_irq_enable(o_global_irq_enable),
    .o_halted(o_halted), .o_wdt_count(o_wdt_count), .o_wdt_prescale(o_wdt_prescale));
  // 100 MHz clock
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // bounded wait; all driving happens 1 ns after an edge
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_op_ready !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n == 40) chk(1'b0, 1'b1, "ready never returned");
  endtask
  // present one op, hold it to the taking edge, then scramble the memory read byte
  task automatic go(input mies_pkg::mies_op_t op, input logic [7:0] m, x, input logic [10:0] a);
    wait_ready();
    i_op = op;
    i_mem_rdata = m;
    i_imm = x;
    i_jump_addr = a;
    i_op_valid = 1;
    @(posedge i_clk);
    #1;
    i_op_valid = 0;
    i_mem_rdata = ~m;
  endtask
  // data op: result lands in memory or accumulator, carry and pc tracked too
  task automatic ex(input mies_pkg::mies_op_t op, input logic [7:0] m, x, res,
                    input logic to_mem, zu);
    go(op, m, x, 11'h000);
    pc_e++;
    chk(o_mem_we, to_mem, "write strobe");
    if (to_mem) chk(o_mem_wdata, res, "memory byte");
    else acc_e = res;
    if (zu) z_e = (res == 8'h00);
    chk(o_acc, acc_e, "accumulator");
    chk(o_zero_flag, z_e, "zero flag");
    chk(o_carry_flag, c_e, "carry flag");
    chk(o_half_carry_flag, 1'b0, "half carry flag");
    chk(o_pc, pc_e, "pc");
  endtask
  task automatic push(input logic irq);
    wait_ready();
    i_call_push = !irq;
    i_irq_taken = irq;
    @(posedge i_clk);
    #1;
    i_call_push = 0;
    i_irq_taken = 0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      i_wdt_tick = 1;
      @(posedge i_clk);
      #1;
      i_wdt_tick = 0;
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic halt_wake();
    go(mies_pkg::MIES_OP_HALT, 8'h00, 8'h00, 11'h000);
    pc_e++;
    chk(o_power_down_flag, 1'b1, "power-down flag");
    chk(o_timeout_flag, 1'b0, "timeout flag");
    chk({o_wdt_count, o_wdt_prescale}, 11'h000, "watchdog");
    chk(o_pc, pc_e, "halt pc");
    repeat (6) @(posedge i_clk);
    #1;
    chk(o_op_ready, 1'b0, "ready while halted");
    chk(o_halted, 1'b1, "halted flag");
    i_wake = 1;
    wait_ready();
    i_wake = 0;
  endtask
  task automatic t_arith();
    ex(mies_pkg::MIES_OP_INC_MEM, 8'hff, 8'h00, 8'h00, 1, 1);
    ex(mies_pkg::MIES_OP_INC_ACC, 8'h7f, 8'h00, 8'h80, 0, 1);
    ex(mies_pkg::MIES_OP_DEC_MEM, 8'h01, 8'h00, 8'h00, 1, 1);
    ex(mies_pkg::MIES_OP_DEC_ACC, 8'h00, 8'h00, 8'hff, 0, 1);
    ex(mies_pkg::MIES_OP_IDLE, 8'h00, 8'h00, acc_e, 0, 0);
    $display("arith test done");
  endtask
  task automatic t_logic();
    ex(mies_pkg::MIES_OP_INV_MEM, 8'hff, 8'h00, 8'h00, 1, 1);
    ex(mies_pkg::MIES_OP_INV_ACC, 8'h5a, 8'h00, 8'ha5, 0, 1);
    ex(mies_pkg::MIES_OP_OR_MEM_ACC, 8'h50, 8'h00, 8'hf5, 0, 1);
    ex(mies_pkg::MIES_OP_MOV_I2A, 8'h00, 8'h00, 8'h00, 0, 0);
    ex(mies_pkg::MIES_OP_OR_IMM_ACC, 8'h00, 8'h00, 8'h00, 0, 1);
    ex(mies_pkg::MIES_OP_OR_TO_MEM, 8'h30, 8'h00, 8'h30, 1, 1);
    $display("logic test done");
  endtask
  task automatic t_move();
    ex(mies_pkg::MIES_OP_DEC_MEM, 8'h01, 8'h00, 8'h00, 1, 1);
    ex(mies_pkg::MIES_OP_MOV_M2A, 8'h3c, 8'h00, 8'h3c, 0, 0);
    ex(mies_pkg::MIES_OP_MOV_A2M, 8'h00, 8'h00, 8'h3c, 1, 0);
    ex(mies_pkg::MIES_OP_ROL_MEM, 8'h81, 8'h00, 8'h03, 1, 0);
    ex(mies_pkg::MIES_OP_ROL_ACC, 8'h80, 8'h00, 8'h01, 0, 0);
    $display("move test done");
  endtask
  // nibble boundaries: untouched, high+carry exactly 9, both adjust, carry forced
  task automatic t_daa();
    logic [7:0] a_in [4] = '{8'h12, 8'h8b, 8'h9a, 8'h45};
    logic [7:0] d_out [4] = '{8'h12, 8'h91, 8'h00, 8'ha5};
    for (int i = 0; i < 4; i++) begin
      ex(mies_pkg::MIES_OP_MOV_I2A, 8'h00, a_in[i], a_in[i], 0, 0);
      if (i == 2) c_e = 1;
      ex(mies_pkg::MIES_OP_DEC_ADJ, 8'h00, 8'h00, d_out[i], 1, 0);
    end
    $display("decimal adjust test done");
  endtask
  task automatic t_flow();
    go(mies_pkg::MIES_OP_JUMP, 8'h00, 8'h00, 11'h123);
    chk(o_pc, 11'h123, "jump pc");
    push(0);
    go(mies_pkg::MIES_OP_JUMP, 8'h00, 8'h00, 11'h456);
    go(mies_pkg::MIES_OP_RET, 8'h00, 8'h00, 11'h000);
    chk(o_pc, 11'h123, "return pc");
    chk(o_zero_flag, z_e, "return flags");
    push(0);
    go(mies_pkg::MIES_OP_RET_IMM, 8'h00, 8'h6e, 11'h000);
    chk(o_acc, 8'h6e, "return value");
    acc_e = 8'h6e;
    push(1);
    go(mies_pkg::MIES_OP_RET_IRQ, 8'h00, 8'h00, 11'h000);
    chk(o_global_irq_enable, 1'b1, "irq enable");
    chk(o_pc, 11'h123, "irq return pc");
    pc_e = 11'h123;
    $display("flow test done");
  endtask
  task automatic t_wdt();
    ticks(300);
    halt_wake();
    ticks(300);
    ex(mies_pkg::MIES_OP_WDT_PRE1, 8'h00, 8'h00, acc_e, 0, 0);
    chk(o_power_down_flag, 1'b1, "lone preclear flag");
    chk(o_wdt_count != 8'h00, 1'b1, "lone preclear count");
    ex(mies_pkg::MIES_OP_WDT_PRE2, 8'h00, 8'h00, acc_e, 0, 0);
    chk({o_power_down_flag, o_timeout_flag, o_wdt_count}, 11'h000, "preclear pair");
    halt_wake();
    // run the watchdog past its wrap so the clear has a timeout to drop
    i_wdt_tick = 1;
    repeat (33152) @(posedge i_clk);
    #1;
    i_wdt_tick = 0;
    chk(o_timeout_flag, 1'b1, "timeout after wrap");
    chk(o_wdt_count, 8'h03, "count after wrap");
    ex(mies_pkg::MIES_OP_WDT_CLR, 8'h00, 8'h00, acc_e, 0, 0);
    chk({o_power_down_flag, o_timeout_flag, o_wdt_count}, 11'h000, "watchdog clear");
    $display("watchdog test done");
  endtask
  task automatic results();
    $display("%0d mismatches in %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, well past the expected run length including the long wrap
  initial begin
    #600000;
    err_count++;
    $display("Error at %0t: run did not finish", $time);
    results();
  end
  initial begin
    {i_reset, i_op_valid, i_wake, i_wdt_tick, i_call_push, i_irq_taken} = 6'h20;
    i_op = mies_pkg::MIES_OP_IDLE;
    {i_imm, i_mem_rdata, i_jump_addr} = 27'h0;
    {err_count, checked, acc_e, z_e, c_e, pc_e} = '0;
    repeat (4) @(posedge i_clk);
    #1;
    i_reset = 0;
    chk({o_pc, o_acc, o_power_down_flag}, 20'h0, "reset state");
    t_arith();
    t_logic();
    t_move();
    t_daa();
    t_flow();
    t_wdt();
    results();
  end
endmodule
`default_nettype wire
